// [src/pcid_pkg.sv]
// Shared constants for the eight-channel pin change interrupt detector.
// Assumes an 8-bit register port with byte addresses as listed below.
package pcid_pkg;

    // Register byte addresses
    localparam logic [7:0] PCID_ADDR_CONTROL = 8'hE9;
    localparam logic [7:0] PCID_ADDR_NEG_EN  = 8'hEA;
    localparam logic [7:0] PCID_ADDR_POS_EN  = 8'hEB;
    localparam logic [7:0] PCID_ADDR_FLAGS   = 8'hEC;

    // Value of every register after reset
    localparam logic [7:0] PCID_RESET_VALUE  = 8'h00;

    // Field positions inside pin_irq_control
    localparam int PCID_TYPE67_BIT   = 7;
    localparam int PCID_TYPE45_BIT   = 6;
    localparam int PCID_TYPE_CH3_BIT = 5;
    localparam int PCID_TYPE_CH0_BIT = 2;
    localparam int PCID_PORT_SEL_MSB = 1;
    localparam int PCID_PORT_SEL_LSB = 0;

    // Port select codes
    typedef enum logic [1:0] {
        PCID_PORT0 = 2'b00,
        PCID_PORT1 = 2'b01,
        PCID_PORT2 = 2'b10,
        PCID_PORT3 = 2'b11
    } pcid_port_t;

endpackage

// [src/pcid_channel.sv]
// One pin interrupt channel: level follower or sticky edge flag.
// Assumes the caller supplies the current and previous pin sample.
`timescale 1ns/1ps
`default_nettype none

module pcid_channel
    import pcid_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Pin samples
    input  wire logic pinNow,
    input  wire logic pinPrev,
    // Configuration
    input  wire logic edgeMode,
    input  wire logic negEnable,
    input  wire logic posEnable,
    // Software clear, edge mode only
    input  wire logic clearReq,
    // Status
    output logic      flag,
    output logic      levelHit
);

    logic riseHit;
    logic fallHit;
    logic next_flag;

    // Flag next value; a new edge beats a clear in the same cycle
    always_comb begin
        riseHit = posEnable & pinNow & ~pinPrev;
        fallHit = negEnable & ~pinNow & pinPrev;
        if (edgeMode) begin
            next_flag = (flag & ~clearReq) | riseHit | fallHit;
        end else begin
            next_flag = ~pinNow;
        end
    end

    // Level request uses the registered flag, so the output is glitch free
    assign levelHit = ~edgeMode & ((negEnable & flag) | (posEnable & ~flag));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

    sequence s_rise;
        edgeMode && posEnable && pinNow && !pinPrev;
    endsequence

    sequence s_fall;
        edgeMode && negEnable && !pinNow && pinPrev;
    endsequence

    a_rise_sets: assert property (@(posedge clk) disable iff (rst)
        s_rise |=> flag) else $error("rising edge did not set flag");

    a_fall_sets: assert property (@(posedge clk) disable iff (rst)
        s_fall |=> flag) else $error("falling edge did not set flag");

    a_edge_sticky: assert property (@(posedge clk) disable iff (rst)
        edgeMode && flag && !clearReq |=> flag) else $error("edge flag dropped");

    a_clear_works: assert property (@(posedge clk) disable iff (rst)
        edgeMode && clearReq && !riseHit && !fallHit |=> !flag)
        else $error("edge flag not cleared");

    a_level_follow: assert property (@(posedge clk) disable iff (rst)
        !edgeMode |=> flag == !$past(pinNow)) else $error("level flag wrong");

endmodule

`default_nettype wire

// [src/pcid_detector.sv]
// Top of the pin change interrupt detector: registers, port mux, channels.
// Assumes pins synchronous to clk and a single-cycle strobed register port.
`timescale 1ns/1ps
`default_nettype none

module pcid_detector
    import pcid_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic      [7:0] regRdata,
    // Input ports
    input  wire logic [7:0] port0Pins,
    input  wire logic [7:0] port1Pins,
    input  wire logic [7:0] port2Pins,
    input  wire logic [7:0] port3Pins,
    // Interrupt request to the processor
    output logic            pinIrq
);

    // Software-visible registers
    logic [7:0] pinIrqControl;
    logic [7:0] pinIrqNegativeEnable;
    logic [7:0] pinIrqPositiveEnable;
    logic [7:0] next_pinIrqControl;
    logic [7:0] next_pinIrqNegativeEnable;
    logic [7:0] next_pinIrqPositiveEnable;

    // Sampling and readback state
    logic [7:0] pinPrev;
    logic [7:0] next_pinPrev;
    logic [7:0] next_regRdata;

    // Derived per-channel signals
    logic [7:0] selPins;
    logic [7:0] channelTriggerType;
    logic [7:0] clearReq;
    logic [7:0] pinIrqFlags;
    logic [7:0] levelHit;
    pcid_port_t portSelect;

    // Decode the control fields
    assign portSelect = pcid_port_t'(pinIrqControl[PCID_PORT_SEL_MSB:PCID_PORT_SEL_LSB]);

    // Channels 6,7 and 4,5 share one type bit; 3..0 have their own
    always_comb begin
        channelTriggerType[7] = pinIrqControl[PCID_TYPE67_BIT];
        channelTriggerType[6] = pinIrqControl[PCID_TYPE67_BIT];
        channelTriggerType[5] = pinIrqControl[PCID_TYPE45_BIT];
        channelTriggerType[4] = pinIrqControl[PCID_TYPE45_BIT];
        channelTriggerType[3:0] =
            pinIrqControl[PCID_TYPE_CH3_BIT:PCID_TYPE_CH0_BIT];
    end

    // Port mux; every code is legal so no default is needed
    always_comb begin
        unique case (portSelect)
            PCID_PORT0: selPins = port0Pins;
            PCID_PORT1: selPins = port1Pins;
            PCID_PORT2: selPins = port2Pins;
            PCID_PORT3: selPins = port3Pins;
        endcase
    end

    // Clear requests: writing 0 to a flag bit clears it if the channel is in edge mode, 1 leaves it
    always_comb begin
        clearReq = 8'h00;
        if (regWrite && (regAddr == PCID_ADDR_FLAGS)) begin
            clearReq = ~regWdata;
        end
    end

    // Register writes and readback
    always_comb begin
        next_pinIrqControl        = pinIrqControl;
        next_pinIrqNegativeEnable = pinIrqNegativeEnable;
        next_pinIrqPositiveEnable = pinIrqPositiveEnable;
        next_regRdata             = 8'h00;
        if (regWrite) begin
            unique case (regAddr)
                PCID_ADDR_CONTROL: next_pinIrqControl        = regWdata;
                PCID_ADDR_NEG_EN:  next_pinIrqNegativeEnable = regWdata;
                PCID_ADDR_POS_EN:  next_pinIrqPositiveEnable = regWdata;
                default: ;
            endcase
        end
        // Unmapped addresses read as zero
        if (regRead) begin
            unique case (regAddr)
                PCID_ADDR_CONTROL: next_regRdata = pinIrqControl;
                PCID_ADDR_NEG_EN:  next_regRdata = pinIrqNegativeEnable;
                PCID_ADDR_POS_EN:  next_regRdata = pinIrqPositiveEnable;
                PCID_ADDR_FLAGS:   next_regRdata = pinIrqFlags;
                default:           next_regRdata = 8'h00;
            endcase
        end
    end

    // Previous sample of the selected port, for edge detection.
    // Changing the port select may look like an edge on some channels.
    assign next_pinPrev = selPins;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinIrqControl        <= PCID_RESET_VALUE;
            pinIrqNegativeEnable <= PCID_RESET_VALUE;
            pinIrqPositiveEnable <= PCID_RESET_VALUE;
            pinPrev              <= PCID_RESET_VALUE;
            regRdata             <= PCID_RESET_VALUE;
        end else begin
            pinIrqControl        <= next_pinIrqControl;
            pinIrqNegativeEnable <= next_pinIrqNegativeEnable;
            pinIrqPositiveEnable <= next_pinIrqPositiveEnable;
            pinPrev              <= next_pinPrev;
            regRdata             <= next_regRdata;
        end
    end

    // One channel per pin bit; channel n watches bit n
    for (genvar n = 0; n < 8; n++) begin : g_channel
        pcid_channel u_channel (
            .clk       (clk),
            .rst       (rst),
            .pinNow    (selPins[n]),
            .pinPrev   (pinPrev[n]),
            .edgeMode  (channelTriggerType[n]),
            .negEnable (pinIrqNegativeEnable[n]),
            .posEnable (pinIrqPositiveEnable[n]),
            .clearReq  (clearReq[n]),
            .flag      (pinIrqFlags[n]),
            .levelHit  (levelHit[n])
        );
    end

    // Edge flags request directly; level channels request through
    // their enabled polarity, since a level flag merely mirrors the inverted pin
    assign pinIrq = (|(pinIrqFlags & channelTriggerType)) | (|levelHit);

    // Checks on configuration routing

    // Written against the control bits, not the type vector, so a type bit
    // routed to the wrong channel makes a level channel stop following its pin
    a_type67_shared: assert property (@(posedge clk) disable iff (rst)
        !pinIrqControl[PCID_TYPE67_BIT]
        |=> pinIrqFlags[7:6] == ~$past(selPins[7:6]))
        else $error("channels 6 and 7 type mismatch");

    a_type45_shared: assert property (@(posedge clk) disable iff (rst)
        !pinIrqControl[PCID_TYPE45_BIT]
        |=> pinIrqFlags[5:4] == ~$past(selPins[5:4]))
        else $error("channels 4 and 5 type mismatch");

    a_type_low_own: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> ((pinIrqFlags[3:0] ^ ~$past(selPins[3:0]))
            & ~$past(pinIrqControl[PCID_TYPE_CH3_BIT:PCID_TYPE_CH0_BIT])) == 4'h0)
        else $error("channels 3 to 0 type mismatch");

    a_port_route: assert property (@(posedge clk) disable iff (rst)
        (pinIrqControl[1:0] == 2'b00 |-> selPins == port0Pins) and
        (pinIrqControl[1:0] == 2'b01 |-> selPins == port1Pins) and
        (pinIrqControl[1:0] == 2'b10 |-> selPins == port2Pins) and
        (pinIrqControl[1:0] == 2'b11 |-> selPins == port3Pins))
        else $error("port select routes wrong port");

    // Checks on the request output

    a_irq_edge_flag: assert property (@(posedge clk) disable iff (rst)
        |(pinIrqFlags & channelTriggerType) |-> pinIrq)
        else $error("edge flag set without request");

    a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
        pinIrqFlags == 8'h00 && pinIrqPositiveEnable == 8'h00 |-> !pinIrq)
        else $error("request without cause");

    // Level requests judged from the last pin sample; only valid while the
    // control byte has not just changed, since the flag lags one cycle
    a_irq_level_low: assert property (@(posedge clk) disable iff (rst)
        $stable(pinIrqControl) &&
        |(~channelTriggerType & pinIrqNegativeEnable & ~pinPrev) |-> pinIrq)
        else $error("enabled low level without request");

    a_irq_level_high: assert property (@(posedge clk) disable iff (rst)
        $stable(pinIrqControl) &&
        |(~channelTriggerType & pinIrqPositiveEnable & pinPrev) |-> pinIrq)
        else $error("enabled high level without request");

    // Checks on register writes and readback

    sequence s_ctrl_write;
        regWrite && regAddr == PCID_ADDR_CONTROL;
    endsequence

    sequence s_ctrl_read;
        regRead && regAddr == PCID_ADDR_CONTROL;
    endsequence

    a_ctrl_readback: assert property (@(posedge clk) disable iff (rst)
        s_ctrl_write ##1 s_ctrl_read |=> regRdata == $past(regWdata, 2))
        else $error("control readback wrong");

    a_read_flags: assert property (@(posedge clk) disable iff (rst)
        regRead && regAddr == PCID_ADDR_FLAGS |=> regRdata == $past(pinIrqFlags))
        else $error("flag readback wrong");

    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !regRead |=> regRdata == 8'h00)
        else $error("read data not zero when idle");

    a_level_no_clear: assert property (@(posedge clk) disable iff (rst)
        regWrite && regAddr == PCID_ADDR_FLAGS && channelTriggerType == 8'h00
        |=> pinIrqFlags == ~$past(selPins))
        else $error("write changed a level flag");

endmodule

`default_nettype wire

// [bench/pcid_pin_model.sv]
// Far-side model: the four I/O ports seen by the pin interrupt detector.
// Assumes the bench chooses which port carries its test pattern.
`timescale 1ns/1ps
`default_nettype none

module pcid_pin_model (
    // Clock
    input  wire logic       clk,
    // Pattern control
    input  wire logic [1:0] sel,
    input  wire logic [7:0] lvl,
    // Port pins
    output logic      [7:0] p0,
    output logic      [7:0] p1,
    output logic      [7:0] p2,
    output logic      [7:0] p3
);
    logic [31:0] noise = 32'h0;

    // Idle ports change every cycle so a wrong port mux cannot hide
    always @(posedge clk) noise <= $urandom;

    // Selected port carries the pattern
    assign p0 = (sel == 2'h0) ? lvl : noise[7:0];
    assign p1 = (sel == 2'h1) ? lvl : noise[15:8];
    assign p2 = (sel == 2'h2) ? lvl : noise[23:16];
    assign p3 = (sel == 2'h3) ? lvl : noise[31:24];
endmodule

`default_nettype wire

// [bench/tb_pin_change_interrupt_detector.sv]
// Self-checking bench for the pin change interrupt detector.
// Assumes a 125 MHz clock and the one-cycle strobed register port.
`timescale 1ns/1ps
`default_nettype none

module tb_pin_change_interrupt_detector
    import pcid_pkg::*;
();
    logic       clk      = 1'b0;
    logic       rst      = 1'b1;
    logic [7:0] regAddr  = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead  = 1'b0;
    logic [7:0] lvl      = 8'h00;
    logic [1:0] pinSel   = 2'h0;
    logic [7:0] regRdata, p0, p1, p2, p3;
    logic       pinIrq;
    int         nErrors = 0, checksDone = 0, cycles = 0;
    // Reference model state
    logic [7:0] ctl, neg, pos, flg, prev, cur, typ, set;
    logic       irq;
    logic [7:0] expRd[$];

    initial begin
        forever #4 clk = ~clk;
    end

    pcid_detector dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .port0Pins(p0), .port1Pins(p1), .port2Pins(p2), .port3Pins(p3), .pinIrq(pinIrq)
    );

    pcid_pin_model pins (
        .clk(clk), .sel(pinSel), .lvl(lvl), .p0(p0), .p1(p1), .p2(p2), .p3(p3)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic completeRun();
        if (nErrors == 0 && checksDone > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One bus cycle; every signal assigned once per edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        regWrite <= w;
        regRead  <= r;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
    endtask

    // Trigger type per channel from the control byte
    function automatic logic [7:0] typeOf(input logic [7:0] c);
        return {c[7], c[7], c[6], c[6], c[5:2]};
    endfunction

    // Reference model; it samples the same pins as the design, so the
    // spurious edges of a port or type change are predicted as well
    always @(posedge clk) begin
        if (rst) begin
            {ctl, neg, pos, flg, prev} = 40'h0;
            irq = 1'b0;
            expRd.delete();
        end else begin
            cycles++;
            if (expRd.size() > 0) check(regRdata, expRd.pop_front(), "read data");
            else check(regRdata, 8'h00, "idle read data");
            check({7'h0, pinIrq}, {7'h0, irq}, "request");
            if (regRead) begin
                case (regAddr)
                    PCID_ADDR_CONTROL: expRd.push_back(ctl);
                    PCID_ADDR_NEG_EN:  expRd.push_back(neg);
                    PCID_ADDR_POS_EN:  expRd.push_back(pos);
                    PCID_ADDR_FLAGS:   expRd.push_back(flg);
                    default:           expRd.push_back(8'h00);
                endcase
            end
            cur = ctl[1] ? (ctl[0] ? p3 : p2) : (ctl[0] ? p1 : p0);
            typ = typeOf(ctl);
            set = (pos & cur & ~prev) | (neg & ~cur & prev);
            if (regWrite && regAddr == PCID_ADDR_FLAGS) flg = flg & (regWdata | ~typ);
            flg = (typ & (flg | set)) | (~typ & ~cur);
            prev = cur;
            if (regWrite && regAddr == PCID_ADDR_CONTROL) ctl = regWdata;
            if (regWrite && regAddr == PCID_ADDR_NEG_EN) neg = regWdata;
            if (regWrite && regAddr == PCID_ADDR_POS_EN) pos = regWdata;
            typ = typeOf(ctl);
            irq = |((typ & flg) | (~typ & ((neg & flg) | (pos & ~flg))));
        end
    end

    // Watchdog; the tests need about 2000 cycles, a hang counts as a mismatch
    initial begin
        wait (cycles > 20000);
        nErrors++;
        completeRun();
    end

    // Main sequence
    initial begin
        int k;
        logic [5:0] typeBits;
        void'($urandom(3));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, unmapped address, read-back
        for (int a = 8'hE8; a <= 8'hED; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
        for (int a = 8'hE8; a <= 8'hEB; a++) bus(1'b1, 1'b0, 8'(a), 8'($urandom));
        for (int a = 8'hE8; a <= 8'hEB; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
        // Random configurations over all four ports, pins wiggled
        // First four rounds all level, next four all edge, then random types
        for (int i = 0; i < 64; i++) begin
            typeBits = (i < 4) ? 6'h00 : (i < 8) ? 6'h3F : 6'($urandom);
            pinSel <= 2'(i);
            bus(1'b1, 1'b0, PCID_ADDR_CONTROL, {typeBits, 2'(i)});
            bus(1'b0, 1'b1, PCID_ADDR_CONTROL, 8'h00);
            bus(1'b1, 1'b0, PCID_ADDR_NEG_EN, 8'($urandom));
            bus(1'b1, 1'b0, PCID_ADDR_POS_EN, 8'($urandom));
            bus(1'b0, 1'b0, 8'h00, 8'h00);
            bus(1'b1, 1'b0, PCID_ADDR_FLAGS, 8'h00);
            repeat (24) begin
                k = $urandom % 3;
                if ($urandom % 2) lvl <= 8'($urandom);
                bus(k == 2, k == 1, PCID_ADDR_FLAGS, 8'($urandom));
            end
        end
        // Reset in mid-run must bring control and both enable registers back to zero; level flags then follow the inverted pins
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 8'hE9; a <= 8'hEC; a++) bus(1'b0, 1'b1, 8'(a), 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        completeRun();
    end
endmodule

`default_nettype wire
